// ===== core/csa_top.sv
// Coprocessor register scan access: test clock chain and processor side sequencer
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
module csa_top import csa_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CSA_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [CSA_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tck,
  input wire logic tap_reset_n,
  input wire logic tdi,
  input wire logic chain_select,
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic update_dr,
  output logic tdo,
  output logic cp_req,
  output logic cp_write,
  output logic [2:0] cp_opc1,
  output logic [2:0] cp_opc2,
  output logic [3:0] cp_primary_reg_field,
  output logic [3:0] cp_secondary_reg_field,
  output logic [CSA_DATA_W-1:0] cp_operand,
  input wire logic cp_addr_legal,
  input wire logic cp_ack,
  input wire logic [CSA_DATA_W-1:0] cp_rdata
);
  // Test clock domain state
  // 48-bit chain and held copy
  logic [CSA_CHAIN_W-1:0] sr_reg, sr_next, hold_reg, hold_next;
  logic launch_tgl_reg, launch_tgl_next, res_rdy_reg, res_rdy_next, rpt_reg, rpt_next;
  logic lat_dir_reg, lat_dir_next;
  logic [CSA_ADDR_W-1:0] lat_addr_reg, lat_addr_next;
  logic [CSA_DATA_W-1:0] lat_data_reg, lat_data_next;
  logic ack_s, pending;
  // Processor clock domain state
  csa_cp_state_e state_reg, state_next;
  logic launch_s, seen_reg, seen_next, ack_tgl_reg, ack_tgl_next;
  logic req_reg, req_next, wr_reg, wr_next, inv_reg, inv_next;
  logic res_read_reg, res_read_next;
  logic [CSA_ADDR_W-1:0] addr_reg, addr_next;
  logic [CSA_DATA_W-1:0] opnd_reg, opnd_next, rdata_reg, rdata_next;
  logic [31:0] dbg_addr, status_word, last_word;

  // Event crossings by toggle, two flip-flops each way
  csa_sync #(.W(1)) u_launch_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .d(launch_tgl_reg),
    .q(launch_s)
  );
  csa_sync #(.W(1)) u_ack_sync (
    .clk(tck),
    .rst_n(tap_reset_n),
    .d(ack_tgl_reg),
    .q(ack_s)
  );

  assign pending = (launch_tgl_reg != ack_s);
  assign tdo = sr_reg[0];

  // Chain capture, shift and update
  always_comb begin
    sr_next = sr_reg;
    hold_next = hold_reg;
    launch_tgl_next = launch_tgl_reg;
    res_rdy_next = res_rdy_reg;
    rpt_next = rpt_reg;
    lat_dir_next = lat_dir_reg;
    lat_addr_next = lat_addr_reg;
    lat_data_next = lat_data_reg;
    if (chain_select) begin
      if (capture_dr) begin
        sr_next = hold_reg;
        if (pending) begin
          sr_next[CSA_FLAG_BIT] = 1'b0;
        end else if (res_rdy_reg) begin
          sr_next[CSA_FLAG_BIT] = 1'b1;
          rpt_next = 1'b1;  // Result has been shown
          if (res_read_reg) sr_next[CSA_DATA_W-1:0] = rdata_reg;
        end
      end else if (shift_dr) begin
        // enter at top, leave at bottom
        sr_next = {tdi, sr_reg[CSA_CHAIN_W-1:1]};
      end else if (update_dr && !pending) begin
        hold_next = sr_reg;
        if (sr_reg[CSA_FLAG_BIT]) begin
          launch_tgl_next = !launch_tgl_reg;
          res_rdy_next = 1'b1;
          rpt_next = 1'b0;
          lat_dir_next = sr_reg[CSA_DIR_BIT];
          lat_addr_next = sr_reg[CSA_ADDR_HI:CSA_ADDR_LO];
          lat_data_next = sr_reg[CSA_DATA_W-1:0];
        end else if (rpt_reg) begin
          // no operation; shown result retires
          // An unshown result survives, so an early poll capture loses nothing
          res_rdy_next = 1'b0;
          rpt_next = 1'b0;
        end
      end
    end
  end

  // Test clock registers
  always_ff @(posedge tck) begin
    if (!tap_reset_n) begin
      sr_reg <= '0;
      hold_reg <= '0;
      launch_tgl_reg <= 1'b0;
      res_rdy_reg <= 1'b0;
      rpt_reg <= 1'b0;
      lat_dir_reg <= 1'b0;
      lat_addr_reg <= '0;
      lat_data_reg <= '0;
    end else begin
      sr_reg <= sr_next;
      hold_reg <= hold_next;
      launch_tgl_reg <= launch_tgl_next;
      res_rdy_reg <= res_rdy_next;
      rpt_reg <= rpt_next;
      lat_dir_reg <= lat_dir_next;
      lat_addr_reg <= lat_addr_next;
      lat_data_reg <= lat_data_next;
    end
  end

  // Processor side sequencer; latched fields are stable while pending
  always_comb begin
    state_next = state_reg;
    seen_next = seen_reg;
    ack_tgl_next = ack_tgl_reg;
    req_next = req_reg;
    wr_next = wr_reg;
    inv_next = inv_reg;
    addr_next = addr_reg;
    opnd_next = opnd_reg;
    rdata_next = rdata_reg;
    res_read_next = res_read_reg;
    case (state_reg)
      CSA_IDLE: begin
        if (launch_s != seen_reg) begin
          seen_next = launch_s;
          state_next = CSA_DECODE;
        end
      end
      CSA_DECODE: begin
        wr_next = lat_dir_reg;
        addr_next = lat_addr_reg;
        if (lat_addr_reg[CSA_PRI_HI:CSA_PRI_LO] == CSA_GRP_DEBUG) begin
          opnd_next = dbg_addr;
        end else begin
          opnd_next = lat_data_reg;
        end
        state_next = CSA_CHECK;
      end
      CSA_CHECK: begin
        inv_next = !cp_addr_legal;
        if (!cp_addr_legal) begin
          wr_next = 1'b0;
          addr_next = CSA_ID_ADDR;
        end
        req_next = 1'b1;
        state_next = CSA_ISSUE;
      end
      CSA_ISSUE: begin
        if (cp_ack) begin
          req_next = 1'b0;
          res_read_next = !wr_reg;
          if (!wr_reg) rdata_next = cp_rdata;
          ack_tgl_next = !ack_tgl_reg;
          state_next = CSA_IDLE;
        end
      end
      default: state_next = CSA_IDLE;
    endcase
  end

  // Processor clock registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= CSA_IDLE;
      seen_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      req_reg <= 1'b0;
      wr_reg <= 1'b0;
      inv_reg <= 1'b0;
      addr_reg <= '0;
      opnd_reg <= '0;
      rdata_reg <= '0;
      res_read_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      seen_reg <= seen_next;
      ack_tgl_reg <= ack_tgl_next;
      req_reg <= req_next;
      wr_reg <= wr_next;
      inv_reg <= inv_next;
      addr_reg <= addr_next;
      opnd_reg <= opnd_next;
      rdata_reg <= rdata_next;
      res_read_reg <= res_read_next;
    end
  end

  assign cp_req = req_reg;
  assign cp_write = wr_reg;
  assign cp_opc1 = addr_reg[CSA_OPC1_HI:CSA_OPC1_LO];
  assign cp_opc2 = addr_reg[CSA_OPC2_HI:CSA_OPC2_LO];
  assign cp_primary_reg_field = addr_reg[CSA_PRI_HI:CSA_PRI_LO];
  assign cp_secondary_reg_field = addr_reg[CSA_SEC_HI:CSA_SEC_LO];
  assign cp_operand = opnd_reg;

  // Status views for software
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[CSA_STAT_BUSY] = (state_reg != CSA_IDLE);
    status_word[CSA_STAT_WRITE] = wr_reg;
    status_word[CSA_STAT_INVALID] = inv_reg;
    status_word[CSA_STAT_RESREAD] = res_read_reg;
    last_word = {18'h00000, addr_reg};
  end

  csa_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .dbg_addr(dbg_addr),
    .status_word(status_word),
    .last_word(last_word)
  );

  // Checks on the test clock side
  a_chain_shift: assert property (@(posedge tck) disable iff (!tap_reset_n)
    chain_select && shift_dr && !capture_dr |=>
      sr_reg == {$past(tdi), $past(sr_reg[CSA_CHAIN_W-1:1])})
    else $error("chain shift wrong");
  a_nop_no_launch: assert property (@(posedge tck) disable iff (!tap_reset_n)
    chain_select && update_dr && !capture_dr && !shift_dr && !sr_reg[CSA_FLAG_BIT] |=>
      $stable(launch_tgl_reg))
    else $error("nop update launched an access");
  a_launch_fields: assert property (@(posedge tck) disable iff (!tap_reset_n)
    chain_select && update_dr && !capture_dr && !shift_dr && sr_reg[CSA_FLAG_BIT] && !pending
      |=> $changed(launch_tgl_reg) && lat_dir_reg == $past(sr_reg[CSA_DIR_BIT])
        && lat_addr_reg == $past(sr_reg[CSA_ADDR_HI:CSA_ADDR_LO]))
    else $error("launch did not take fields");
  a_hold_recirc: assert property (@(posedge tck) disable iff (!tap_reset_n)
    chain_select && update_dr && !capture_dr && !shift_dr && !sr_reg[CSA_FLAG_BIT] && !pending
      |=> hold_reg == $past(sr_reg))
    else $error("recirculated value lost");
  a_capture_hold: assert property (@(posedge tck) disable iff (!tap_reset_n)
    chain_select && capture_dr && !pending && !res_rdy_reg |=> sr_reg == $past(hold_reg))
    else $error("recirculated value not returned");
  a_capture_busy: assert property (@(posedge tck) disable iff (!tap_reset_n)
    chain_select && capture_dr && pending |=> !sr_reg[CSA_FLAG_BIT])
    else $error("pending access reported complete");
  a_capture_read: assert property (@(posedge tck) disable iff (!tap_reset_n)
    chain_select && capture_dr && !pending && res_rdy_reg && res_read_reg |=>
      sr_reg[CSA_FLAG_BIT] && sr_reg[CSA_DATA_W-1:0] == rdata_reg)
    else $error("read result not captured");
  // Checks on the processor clock side; the last cover, c_poll_complete, is on the test clock
  a_addr_fields: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == CSA_DECODE |=> cp_opc1 == lat_addr_reg[CSA_OPC1_HI:CSA_OPC1_LO]
      && cp_primary_reg_field == lat_addr_reg[CSA_PRI_HI:CSA_PRI_LO])
    else $error("address fields mismapped");
  a_invalid_id: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == CSA_CHECK && !cp_addr_legal |=> cp_req && !cp_write && addr_reg == CSA_ID_ADDR)
    else $error("illegal encoding not turned into id read");
  a_debug_selector: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == CSA_DECODE && lat_addr_reg[CSA_PRI_HI:CSA_PRI_LO] == CSA_GRP_DEBUG
      |=> cp_operand == $past(dbg_addr))
    else $error("debug group selector not from debug address");
  a_cache_selector: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == CSA_DECODE && (lat_addr_reg[CSA_PRI_HI:CSA_PRI_LO] == CSA_GRP_CACHE
      || lat_addr_reg[CSA_PRI_HI:CSA_PRI_LO] == CSA_GRP_TLB) |=> cp_operand == lat_data_reg)
    else $error("maintenance selector not from scan data");
  a_launch_to_req: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == CSA_IDLE && launch_s != seen_reg |-> ##3 cp_req)
    else $error("launch did not reach request");
  c_write_done: cover property (@(posedge aclk) disable iff (!aresetn)
    cp_req && cp_write && cp_ack);
  c_read_done: cover property (@(posedge aclk) disable iff (!aresetn)
    cp_req && !cp_write && cp_ack);
  c_invalid: cover property (@(posedge aclk) disable iff (!aresetn)
    state_reg == CSA_CHECK && !cp_addr_legal);
  c_poll_complete: cover property (@(posedge tck) disable iff (!tap_reset_n)
    chain_select && capture_dr && !pending && res_rdy_reg);
endmodule // csa_top

// ===== core/csa_pkg.sv
// Constants and types shared by the coprocessor scan access block
package csa_pkg;
  // Scan chain layout
  localparam int CSA_CHAIN_W = 48;
  localparam int CSA_DIR_BIT = 47;
  localparam int CSA_ADDR_HI = 46;
  localparam int CSA_ADDR_LO = 33;
  localparam int CSA_ADDR_W = 14;
  localparam int CSA_FLAG_BIT = 32;
  localparam int CSA_DATA_W = 32;
  // Fields inside the 14-bit address
  localparam int CSA_OPC1_HI = 13;
  localparam int CSA_OPC1_LO = 11;
  localparam int CSA_OPC2_HI = 10;
  localparam int CSA_OPC2_LO = 8;
  localparam int CSA_PRI_HI = 7;
  localparam int CSA_PRI_LO = 4;
  localparam int CSA_SEC_HI = 3;
  localparam int CSA_SEC_LO = 0;
  // Register groups that take an entry selector
  localparam logic [3:0] CSA_GRP_CACHE = 4'h7;
  localparam logic [3:0] CSA_GRP_TLB = 4'h8;
  localparam logic [3:0] CSA_GRP_DEBUG = 4'hf;
  // Address used when the requested encoding is illegal (identification register)
  localparam logic [CSA_ADDR_W-1:0] CSA_ID_ADDR = 14'h0000;
  // Register bus map
  localparam int CSA_AXI_AW = 4;
  localparam logic [CSA_AXI_AW-1:0] CSA_OFF_DBG_ADDR = 4'h0;
  localparam logic [CSA_AXI_AW-1:0] CSA_OFF_STATUS = 4'h4;
  localparam logic [CSA_AXI_AW-1:0] CSA_OFF_LAST = 4'h8;
  localparam logic [31:0] CSA_DBG_ADDR_RST = 32'h0000_0000;
  localparam int CSA_STAT_BUSY = 0;
  localparam int CSA_STAT_WRITE = 1;
  localparam int CSA_STAT_INVALID = 2;
  localparam int CSA_STAT_RESREAD = 3;
  localparam logic [1:0] CSA_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSA_RESP_SLVERR = 2'h2;
  // Processor side access sequencer
  typedef enum logic [1:0] {CSA_IDLE, CSA_DECODE, CSA_CHECK, CSA_ISSUE} csa_cp_state_e;
endpackage

// ===== core/csa_sync.sv
// Two flip-flop level synchroniser
module csa_sync import csa_pkg::*; #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // csa_sync

// ===== core/csa_axil.sv
// AXI4-Lite slave holding the debug address and status view
module csa_axil import csa_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CSA_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [CSA_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] dbg_addr,
  input wire logic [31:0] status_word,
  input wire logic [31:0] last_word
);
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [CSA_AXI_AW-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, dbg_reg, dbg_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;

  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready = !w_hold_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign dbg_addr = dbg_reg;

  // Next state for both channels
  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next = w_hold_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    dbg_next = dbg_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid && !aw_hold_reg) begin
      aw_hold_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_reg) begin
      w_hold_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_hold_reg && w_hold_reg && !bvalid_reg) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = CSA_RESP_OKAY;
      if (awaddr_reg == CSA_OFF_DBG_ADDR) begin
        for (int i = 0; i < 4; i++) begin
          if (wstrb_reg[i]) dbg_next[8*i +: 8] = wdata_reg[8*i +: 8];
        end
      end else if (awaddr_reg != CSA_OFF_STATUS && awaddr_reg != CSA_OFF_LAST) begin
        bresp_next = CSA_RESP_SLVERR;
      end
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = CSA_RESP_OKAY;
      case (s_axi_araddr)
        CSA_OFF_DBG_ADDR: rdata_next = dbg_reg;
        CSA_OFF_STATUS: rdata_next = status_word;
        CSA_OFF_LAST: rdata_next = last_word;
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = CSA_RESP_SLVERR;
        end
      endcase
    end
  end

  // Register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      dbg_reg <= CSA_DBG_ADDR_RST;
      bvalid_reg <= 1'b0;
      bresp_reg <= CSA_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= CSA_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      dbg_reg <= dbg_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule // csa_axil

// ===== sim/csa_debugger.sv
// Debugger model that drives the access chain through its scan strobes
module csa_debugger (
  input wire logic tck,
  input wire logic tdo,
  output logic tdi,
  output logic chain_select,
  output logic capture_dr,
  output logic shift_dr,
  output logic update_dr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {tdi, chain_select, capture_dr, shift_dr, update_dr} = 5'h0;
  end
  // capture, then 48 shifts low bit first, then update
  task automatic scan(input logic [47:0] din, output logic [47:0] dout);
    @(posedge tck);
    chain_select <= 1'b1;
    capture_dr <= 1'b1;
    @(posedge tck);
    capture_dr <= 1'b0;
    shift_dr <= 1'b1;
    tdi <= din[0];
    for (int i = 0; i < 48; i++) begin
      @(negedge tck);
      dout[i] = tdo;
      @(posedge tck);
      tdi <= (i < 47) ? din[i+1] : ~din[47];  // Unused line shows a changed level
    end
    shift_dr <= 1'b0;
    update_dr <= 1'b1;
    @(posedge tck);
    update_dr <= 1'b0;
    chain_select <= 1'b0;
  endtask
endmodule // csa_debugger

// ===== sim/csa_top_test.sv
// Testbench for the coprocessor scan access block
module csa_top_test import csa_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic tck = 1'b0;
  logic aresetn = 1'b0;
  logic tap_reset_n = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cp_ack = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, cp_rdata = 32'h0, s_axi_rdata, cp_operand, last_op;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic tdi, chain_select, capture_dr, shift_dr, update_dr, tdo, cp_req, cp_write, last_wr;
  logic cp_addr_legal;
  logic [2:0] cp_opc1, cp_opc2;
  logic [3:0] cp_primary_reg_field, cp_secondary_reg_field;
  logic [13:0] last_addr;
  logic [47:0] q, v;
  int n_mismatch = 0, cmp_count = 0, n_req = 0, lat = 0, wait_n = 0;

  csa_top i_dut (.*);
  csa_debugger dbg (.*);

  // Processor clock and unrelated test clock
  always #10 aclk = ~aclk;
  always #16 tck = ~tck;

  function automatic logic [31:0] rd_val(input logic [13:0] a);
    return 32'ha5a5_0000 | {18'h0, a};
  endfunction

  // Coprocessor responder: one primary group counts as illegal
  assign cp_addr_legal = (cp_primary_reg_field !== 4'he);
  always @(posedge aclk) begin
    cp_ack <= 1'b0;
    cp_rdata <= ~cp_rdata;
    if (cp_req === 1'b1 && !cp_ack) begin
      if (wait_n >= lat) begin
        cp_ack <= 1'b1;
        cp_rdata <= rd_val({cp_opc1, cp_opc2, cp_primary_reg_field, cp_secondary_reg_field});
        last_addr <= {cp_opc1, cp_opc2, cp_primary_reg_field, cp_secondary_reg_field};
        last_op <= cp_operand;
        last_wr <= cp_write;
        n_req <= n_req + 1;
        wait_n <= 0;
      end else begin
        wait_n <= wait_n + 1;
      end
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end while (s_axi_bvalid !== 1'b1 && k < 50);
    s_axi_bready <= 1'b0;
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end while (s_axi_rvalid !== 1'b1 && k < 50);
    s_axi_rready <= 1'b0;
    chk({s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {1'b1, er, ed});
  endtask

  // Launch one access, then poll with no-operation scans
  task automatic access(input logic wr, input logic [13:0] a, input logic [31:0] d);
    int k;
    dbg.scan({wr, a, 1'b1, d}, q);
    k = 0;
    do begin
      dbg.scan(48'h0, q);
      k++;
    end while (q[32] !== 1'b1 && k < 40);
    chk(q[32], 1'b1);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #400_000;
    n_mismatch++;
    complete_run;
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    tap_reset_n <= 1'b1;
    axi_rd(CSA_OFF_DBG_ADDR, CSA_DBG_ADDR_RST, CSA_RESP_OKAY);
    axi_wr(CSA_OFF_DBG_ADDR, 32'h1234_5678, 4'hf, CSA_RESP_OKAY);
    axi_wr(CSA_OFF_DBG_ADDR, 32'hffff_ffff, 4'h3, CSA_RESP_OKAY);
    axi_rd(CSA_OFF_DBG_ADDR, 32'h1234_ffff, CSA_RESP_OKAY);
    axi_wr(4'hc, 32'h1, 4'hf, CSA_RESP_SLVERR);
    axi_rd(4'hc, 32'h0, CSA_RESP_SLVERR);
    axi_rd(CSA_OFF_STATUS, 32'h0, CSA_RESP_OKAY);
    v = {1'b1, 14'h2abc, 1'b0, 32'hcafe_f00d};
    dbg.scan(v, q);
    chk(q, 48'h0);
    dbg.scan(v, q);
    chk(q, v);
    chk(48'(n_req), 48'h0);
    // preset data, then launch with upper bits
    dbg.scan({15'h0, 1'b0, 32'h0bad_cafe}, q);
    access(1'b1, {3'h0, 3'h1, 4'h7, 4'ha}, 32'h0bad_cafe);
    chk({last_wr, last_addr, last_op}, {1'b1, 14'h017a, 32'h0bad_cafe});
    access(1'b1, {3'h0, 3'h2, 4'hf, 4'h1}, 32'h5555_0000);
    chk(last_op, 32'h1234_ffff);
    lat = 200;
    access(1'b0, {3'h1, 3'h3, 4'h2, 4'h0}, 32'h0);
    chk(q[31:0], rd_val(14'h0b20));
    chk({last_wr, last_addr}, {1'b0, 14'h0b20});
    axi_rd(CSA_OFF_LAST, 32'h0000_0b20, CSA_RESP_OKAY);
    axi_rd(CSA_OFF_STATUS, 32'h1 << CSA_STAT_RESREAD, CSA_RESP_OKAY);
    lat = 0;
    access(1'b1, {3'h0, 3'h0, 4'he, 4'h3}, 32'h1);
    chk({last_wr, last_addr, q[31:0]}, {1'b0, CSA_ID_ADDR, rd_val(CSA_ID_ADDR)});
    axi_rd(CSA_OFF_STATUS, (32'h1 << CSA_STAT_INVALID) | (32'h1 << CSA_STAT_RESREAD),
           CSA_RESP_OKAY);
    chk(48'(n_req), 48'h4);
    complete_run;
  end
endmodule // csa_top_test
